/* File: hw/nand_regs.svh */
// Opcodes, feature addresses, field positions, reset values and timing
// counts of the serial NAND front end. Assumes a 40 MHz system clock.
`ifndef NAND_REGS_SVH
`define NAND_REGS_SVH

`define OP_WRITE_ENABLE_CMD   8'h06
`define OP_WRDI   8'h04
`define OP_GETF   8'h0f
`define OP_SETF   8'h1f
`define OP_PREAD  8'h13
`define OP_RD1    8'h03
`define OP_RDF    8'h0b
`define OP_RD2    8'h3b
`define OP_RD4    8'h6b
`define OP_RDIO2  8'hbb
`define OP_RDIO4  8'heb
`define OP_RDID   8'h9f
`define OP_LD     8'h02
`define OP_LD4    8'h32
`define OP_LDR    8'h84
`define OP_LDR4   8'h34
`define OP_PEXEC  8'h10
`define OP_RESET  8'hff

`define FA_LOCK   8'ha0
`define FA_OTP    8'hb0
`define FA_STAT   8'hc0
`define FA_DRV    8'hd0

`define LOCK_RST  8'h00
`define OTP_RST   8'h10
`define DRV_RST   8'h00
`define OTP_WMASK 8'hf0
`define DRV_WMASK 8'h60

`define BIT_WPE   1
`define BIT_OIP   0
`define BIT_WEL   1
`define BIT_PFAIL 3

`define CACHE_LEN 2176
`define MFR_ID    8'h5a
`define DEV_ID    8'h3c

`define CLK_MHZ       40
`define PAGE_READ_US  20
`define PAGE_PROG_US  200
`define PAGE_READ_CYC (`PAGE_READ_US * `CLK_MHZ)
`define PAGE_PROG_CYC (`PAGE_PROG_US * `CLK_MHZ)

`endif

/* File: hw/nand_pkg.sv */
// Types shared by the serial NAND front end.
// Assumes nothing beyond a SystemVerilog compiler.
package nand_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_PROG} busy_state_t;
endpackage

/* File: hw/nand_buffers.sv */
// Shift-register FIFO and the cache memory of the serial NAND front end.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module nand_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // System
    input  wire logic             clk,
    input  wire logic             resetn,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    logic [WIDTH-1:0] data_reg [DEPTH];
    logic [DEPTH-1:0] valid_reg;
    logic [DEPTH-1:0] sv_all;
    logic             pop;
    logic             push;

    // Head always sits in entry 0, so the drain side reads flops only
    assign pop       = valid_reg[0] & out_ready;
    assign push      = in_valid & in_ready;
    assign in_ready  = ~valid_reg[DEPTH-1];
    assign out_data  = data_reg[0];
    assign out_valid = valid_reg[0];
    assign sv_all    = pop ? (valid_reg >> 1) : valid_reg;

    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        logic             prev_full;
        logic             take;
        logic [WIDTH-1:0] nxt_data;
        logic             v_q;
        logic [WIDTH-1:0] d_q;
        if (i == 0) begin : g_first
            assign prev_full = 1'b1;
        end else begin : g_rest
            assign prev_full = sv_all[i-1];
        end
        if (i == DEPTH - 1) begin : g_last
            assign nxt_data = d_q;
        end else begin : g_mid
            assign nxt_data = data_reg[i+1];
        end
        assign take         = push & ~sv_all[i] & prev_full;
        assign valid_reg[i] = v_q;
        assign data_reg[i]  = d_q;
        always_ff @(posedge clk) begin
            if (!resetn) begin
                v_q <= 1'b0;
            end else begin
                v_q <= sv_all[i] | take;
            end
        end
        always_ff @(posedge clk) begin
            if (take) begin
                d_q <= in_data;
            end else if (pop) begin
                d_q <= nxt_data;
            end
        end
    end
endmodule

module nand_cache_mem #(
    parameter int DEPTH = 2176,
    parameter int AW    = 12
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic [7:0]         rdata
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we && addr < AW'(DEPTH)) begin
            mem[addr] <= wdata;
        end
        rdata <= (addr < AW'(DEPTH)) ? mem[addr] : 8'h00;
    end
endmodule

`default_nettype wire

/* File: hw/nand_front.sv */
// Command sequencer of a serial NAND device: feature registers, page read
// into cache, cache readout on 1/2/4 lines, identifier, program load,
// random load and program execute towards an array port.
// Assumes link pins are asynchronous and the array logic shares clk.
`timescale 1ns/1ps
`default_nettype none
`include "nand_regs.svh"

module nand_front
    import nand_pkg::*;
#(
    parameter nand_pkg::byte_t MFR_ID     = `MFR_ID,
    parameter nand_pkg::byte_t DEV_ID     = `DEV_ID,
    parameter int              READ_CYC   = `PAGE_READ_CYC,
    parameter int              PROG_CYC   = `PAGE_PROG_CYC,
    parameter int              CACHE_LEN  = `CACHE_LEN,
    parameter int              FIFO_DEPTH = 4
) (
    // System
    input  wire logic           clk,
    input  wire logic           resetn,
    // Link pins
    input  wire logic           link_sclk,
    input  wire logic           link_cs_n,
    input  wire logic [3:0]     dq_in,
    output logic [3:0]          dq_out,
    output logic [3:0]          dq_oe,
    // Array port
    output logic [15:0]         arr_row,
    output logic                arr_rd_start,
    output logic                arr_wr_start,
    input  wire nand_pkg::byte_t arr_rdata,
    input  wire logic           arr_rvalid,
    output nand_pkg::byte_t     arr_wdata,
    output logic                arr_wvalid,
    input  wire logic           arr_wready,
    input  wire logic           arr_prog_fail
);
    import nand_pkg::*;

    localparam int CW = 12;
    localparam logic [CW-1:0] LEN = CW'(CACHE_LEN);

    logic            cs_m, cs_s, ck_m, ck_s, ck_d;
    logic [3:0]      dq_m, dq_s;
    logic            rise, fall;
    logic [7:0]      sh_reg, sh_next;
    logic [3:0]      bcnt_reg;
    logic [2:0]      in_w_reg, out_w_reg, bidx_reg;
    logic            byte_done;
    logic [7:0]      op_reg, faddr_reg, rowhi_reg;
    logic            ign_reg, out_en_reg;
    logic [CW-1:0]   col_reg;
    logic [3:0]      obits_reg;
    logic [7:0]      osh_reg;
    logic            id_sel_reg;
    busy_state_t     state_reg;
    logic [23:0]     tmr_reg;
    logic [CW-1:0]   xcnt_reg;
    logic            pend_reg;
    logic            wel_reg, pfail_reg;
    logic [7:0]      lock_reg, otp_reg, drv_reg;
    logic            operation_in_progress;
    logic            op_fire, active;
    logic            ev_write_enable_cmd, ev_wrdi, ev_reset, ev_setf;
    logic            ev_pread, ev_pexec, ev_ld, out_take;
    logic [7:0]      feat_rd, status, out_src, cur;
    logic [3:0]      nib, oe_mask;
    logic            mem_we;
    logic [CW-1:0]   mem_addr;
    logic [7:0]      mem_wd, mem_rdata;
    logic            fifo_ready;

    function automatic logic is_read(input logic [7:0] op);
        return op == `OP_RD1 || op == `OP_RDF || op == `OP_RD2 ||
               op == `OP_RD4 || op == `OP_RDIO2 || op == `OP_RDIO4;
    endfunction

    function automatic logic is_load(input logic [7:0] op);
        return op == `OP_LD || op == `OP_LD4 || op == `OP_LDR || op == `OP_LDR4;
    endfunction

    function automatic logic is_x4_load(input logic [7:0] op);
        return op == `OP_LD4 || op == `OP_LDR4;
    endfunction

    function automatic logic busy_ok(input logic [7:0] op);
        return op == `OP_GETF || op == `OP_RESET || op == `OP_RDID;
    endfunction

    // Pin synchronisers; select and clock share latency so order holds
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            ck_m <= 1'b0;
            ck_s <= 1'b0;
            ck_d <= 1'b0;
            dq_m <= 4'h0;
            dq_s <= 4'h0;
        end else begin
            cs_m <= link_cs_n;
            cs_s <= cs_m;
            ck_m <= link_sclk;
            ck_s <= ck_m;
            ck_d <= ck_s;
            dq_m <= dq_in;
            dq_s <= dq_m;
        end
    end

    assign rise = ck_s & ~ck_d & ~cs_s;
    assign fall = ~ck_s & ck_d & ~cs_s;
    assign operation_in_progress  = state_reg != ST_IDLE;

    // Input shifter, width follows the command phase
    always_comb begin
        case (in_w_reg)
            3'd4:    sh_next = {sh_reg[3:0], dq_s};
            3'd2:    sh_next = {sh_reg[5:0], dq_s[1:0]};
            default: sh_next = {sh_reg[6:0], dq_s[0]};
        endcase
    end

    assign byte_done = rise && (bcnt_reg + {1'b0, in_w_reg}) == 4'd8;

    always_ff @(posedge clk) begin
        if (!resetn || cs_s) begin
            sh_reg   <= 8'h00;
            bcnt_reg <= 4'h0;
        end else if (rise) begin
            sh_reg   <= sh_next;
            bcnt_reg <= byte_done ? 4'h0 : bcnt_reg + {1'b0, in_w_reg};
        end
    end

    // Command events
    assign op_fire  = byte_done && bidx_reg == 3'd0;
    assign active   = byte_done && bidx_reg != 3'd0 && !ign_reg;
    assign ev_write_enable_cmd  = op_fire && !operation_in_progress && sh_next == `OP_WRITE_ENABLE_CMD;
    assign ev_wrdi  = op_fire && !operation_in_progress && sh_next == `OP_WRDI;
    assign ev_reset = op_fire && sh_next == `OP_RESET;
    assign ev_setf  = active && op_reg == `OP_SETF && bidx_reg == 3'd2;
    assign ev_pread = active && op_reg == `OP_PREAD && bidx_reg == 3'd3;
    assign ev_pexec = active && op_reg == `OP_PEXEC && bidx_reg == 3'd3;
    assign ev_ld    = active && is_load(op_reg) && bidx_reg >= 3'd3;

    // Command framing; select high ends every command
    always_ff @(posedge clk) begin
        if (!resetn || cs_s) begin
            op_reg     <= 8'h00;
            bidx_reg   <= 3'd0;
            ign_reg    <= 1'b0;
            in_w_reg   <= 3'd1;
            out_w_reg  <= 3'd1;
            out_en_reg <= 1'b0;
            faddr_reg  <= 8'h00;
            rowhi_reg  <= 8'h00;
        end else if (byte_done) begin
            if (bidx_reg != 3'd7) begin
                bidx_reg <= bidx_reg + 3'd1;
            end
            if (bidx_reg == 3'd0) begin
                op_reg  <= sh_next;
                ign_reg <= (operation_in_progress && !busy_ok(sh_next)) ||
                           (is_x4_load(sh_next) && lock_reg[`BIT_WPE]);
                case (sh_next)
                    `OP_RDIO2: in_w_reg <= 3'd2;
                    `OP_RDIO4: in_w_reg <= 3'd4;
                    default: ;
                endcase
                case (sh_next)
                    `OP_RD2, `OP_RDIO2: out_w_reg <= 3'd2;
                    `OP_RD4, `OP_RDIO4: out_w_reg <= 3'd4;
                    default:            out_w_reg <= 3'd1;
                endcase
            end else if (!ign_reg) begin
                if (bidx_reg == 3'd1) begin
                    faddr_reg <= sh_next;
                end
                if (bidx_reg == 3'd2) begin
                    rowhi_reg <= sh_next;
                end
                if (bidx_reg == 3'd2 && is_x4_load(op_reg)) begin
                    in_w_reg <= 3'd4;
                end
                if ((op_reg == `OP_GETF || op_reg == `OP_RDID) && bidx_reg == 3'd1) begin
                    out_en_reg <= 1'b1;
                end
                // Quad-IO readout carries two trailing dummy bytes
                if (is_read(op_reg) &&
                    bidx_reg == (op_reg == `OP_RDIO4 ? 3'd4 : 3'd3)) begin
                    out_en_reg <= 1'b1;
                end
            end
        end
    end

    // Column pointer; saturates at the cache end so nothing wraps to 0
    always_ff @(posedge clk) begin
        if (!resetn) begin
            col_reg <= '0;
        end else if (active && bidx_reg == 3'd1) begin
            col_reg <= {sh_next[3:0], col_reg[7:0]};
        end else if (active && bidx_reg == 3'd2) begin
            col_reg <= {col_reg[11:8], sh_next};
        end else if ((ev_ld || (out_take && is_read(op_reg))) && col_reg < LEN) begin
            col_reg <= col_reg + 12'd1;
        end
    end

    // Feature registers; only power-on reset restores them
    always_ff @(posedge clk) begin
        if (!resetn) begin
            lock_reg <= `LOCK_RST;
            otp_reg  <= `OTP_RST;
            drv_reg  <= `DRV_RST;
        end else if (ev_setf) begin
            case (faddr_reg)
                `FA_LOCK: lock_reg <= sh_next;
                `FA_OTP:  otp_reg  <= sh_next & `OTP_WMASK;
                `FA_DRV:  drv_reg  <= sh_next & `DRV_WMASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wel_reg <= 1'b0;
        end else if (ev_write_enable_cmd) begin
            wel_reg <= 1'b1;
        end else if (ev_wrdi || ev_pexec) begin
            wel_reg <= 1'b0;
        end
    end

    // Failure report from the array; a new fail beats a same-cycle clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pfail_reg <= 1'b0;
        end else if (arr_prog_fail) begin
            pfail_reg <= 1'b1;
        end else if (ev_reset || (ev_pexec && wel_reg)) begin
            pfail_reg <= 1'b0;
        end
    end

    always_comb begin
        status               = 8'h00;
        status[`BIT_OIP]     = operation_in_progress;
        status[`BIT_WEL]     = wel_reg;
        status[`BIT_PFAIL]   = pfail_reg;
        case (faddr_reg)
            `FA_LOCK: feat_rd = lock_reg;
            `FA_OTP:  feat_rd = otp_reg;
            `FA_STAT: feat_rd = status;
            `FA_DRV:  feat_rd = drv_reg;
            default:  feat_rd = 8'h00;
        endcase
    end

    // Output source and lane placement
    always_comb begin
        if (op_reg == `OP_GETF) begin
            out_src = feat_rd;
        end else if (op_reg == `OP_RDID) begin
            out_src = id_sel_reg ? DEV_ID : MFR_ID;
        end else begin
            out_src = (col_reg < LEN) ? mem_rdata : 8'hff;
        end
        cur = (obits_reg == 4'd0) ? out_src : osh_reg;
        case (out_w_reg)
            3'd4: begin
                nib     = cur[7:4];
                oe_mask = 4'hf;
            end
            3'd2: begin
                nib     = {2'b00, cur[7:6]};
                oe_mask = 4'h3;
            end
            default: begin
                nib     = {2'b00, cur[7], 1'b0};
                oe_mask = 4'h2;
            end
        endcase
    end

    assign out_take = fall && out_en_reg && obits_reg == 4'd0;

    // Drives on falling edges so the host samples on the next rise
    always_ff @(posedge clk) begin
        if (!resetn || cs_s) begin
            dq_out     <= 4'h0;
            dq_oe      <= 4'h0;
            obits_reg  <= 4'h0;
            osh_reg    <= 8'h00;
            id_sel_reg <= 1'b0;
        end else if (fall && out_en_reg) begin
            dq_out    <= nib;
            dq_oe     <= oe_mask;
            osh_reg   <= cur << out_w_reg;
            obits_reg <= (obits_reg == 4'd0 ? 4'd8 : obits_reg) - {1'b0, out_w_reg};
            if (out_take && op_reg == `OP_RDID) begin
                id_sel_reg <= 1'b1;
            end
        end
    end

    // Busy sequencer for page read and program execute
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            tmr_reg   <= 24'h0;
            xcnt_reg  <= '0;
            pend_reg  <= 1'b0;
        end else begin
            pend_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (ev_pread) begin
                        state_reg <= ST_READ;
                        tmr_reg   <= 24'(READ_CYC);
                        xcnt_reg  <= '0;
                    end else if (ev_pexec && wel_reg) begin
                        state_reg <= ST_PROG;
                        tmr_reg   <= 24'(PROG_CYC);
                        xcnt_reg  <= '0;
                    end
                end
                ST_READ: begin
                    if (tmr_reg != 24'h0) begin
                        tmr_reg <= tmr_reg - 24'h1;
                    end
                    if (arr_rvalid && xcnt_reg < LEN) begin
                        xcnt_reg <= xcnt_reg + 12'd1;
                    end
                    if (tmr_reg == 24'h0 && xcnt_reg == LEN) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_PROG: begin
                    if (tmr_reg != 24'h0) begin
                        tmr_reg <= tmr_reg - 24'h1;
                    end
                    // One read in flight; FIFO room stalls the cache walk
                    if (!pend_reg && fifo_ready && xcnt_reg < LEN) begin
                        pend_reg <= 1'b1;
                        xcnt_reg <= xcnt_reg + 12'd1;
                    end
                    if (tmr_reg == 24'h0 && xcnt_reg == LEN && !pend_reg && !arr_wvalid) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
            if (ev_reset) begin
                state_reg <= ST_IDLE;
                pend_reg  <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            arr_row      <= 16'h0000;
            arr_rd_start <= 1'b0;
            arr_wr_start <= 1'b0;
        end else begin
            arr_rd_start <= ev_pread;
            arr_wr_start <= ev_pexec && wel_reg;
            if (ev_pread || ev_pexec) begin
                arr_row <= {rowhi_reg, sh_next};
            end
        end
    end

    // Cache port: busy sequencer owns it, otherwise the column does
    always_comb begin
        mem_we   = 1'b0;
        mem_addr = col_reg;
        mem_wd   = sh_next;
        case (state_reg)
            ST_READ: begin
                mem_we   = arr_rvalid && xcnt_reg < LEN;
                mem_addr = xcnt_reg;
                mem_wd   = arr_rdata;
            end
            ST_PROG: mem_addr = xcnt_reg;
            default: mem_we = ev_ld && col_reg < LEN;
        endcase
    end

    nand_cache_mem #(
        .DEPTH (CACHE_LEN),
        .AW    (CW)
    ) u_cache (
        .clk   (clk),
        .we    (mem_we),
        .addr  (mem_addr),
        .wdata (mem_wd),
        .rdata (mem_rdata)
    );

    nand_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_data   (mem_rdata),
        .in_valid  (pend_reg),
        .in_ready  (fifo_ready),
        .out_data  (arr_wdata),
        .out_valid (arr_wvalid),
        .out_ready (arr_wready)
    );
endmodule

`default_nettype wire

/* File: tb/nand_front_chk.sv */
// Port assertions for the serial NAND front end.
// Assumes one clk domain; bound to nand_front from the bench.
`timescale 1ns/1ps
`default_nettype none
module nand_front_chk
    import nand_pkg::*;
(
    // Watched ports
    input wire logic            clk,
    input wire logic            resetn,
    input wire logic            link_cs_n,
    input wire logic [3:0]      dq_oe,
    input wire logic            arr_rd_start,
    input wire logic            arr_wr_start,
    input wire nand_pkg::byte_t arr_wdata,
    input wire logic            arr_wvalid,
    input wire logic            arr_wready
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_idle; link_cs_n [*5] |-> dq_oe == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("drive outside frame");
    property p_lanes; dq_oe inside {4'h0, 4'h2, 4'h3, 4'hf}; endproperty
    a_lanes: assert property (p_lanes) else $error("bad lanes");
    property p_head; $fell(link_cs_n) |-> dq_oe == 4'h0 [*4]; endproperty
    a_head: assert property (p_head) else $error("drive in opcode");
    property p_rd; arr_rd_start |=> !arr_rd_start; endproperty
    a_rd: assert property (p_rd) else $error("long read start");
    property p_wr; arr_wr_start |=> !arr_wr_start; endproperty
    a_wr: assert property (p_wr) else $error("long write start");
    property p_busy; arr_rd_start |=> !arr_wr_start [*8]; endproperty
    a_busy: assert property (p_busy) else $error("write while busy");
    property p_hold; arr_wvalid & !arr_wready |=> arr_wvalid & $stable(arr_wdata); endproperty
    a_hold: assert property (p_hold) else $error("byte dropped");
    property p_frame; link_cs_n [*6] |-> !arr_rd_start & !arr_wr_start; endproperty
    a_frame: assert property (p_frame) else $error("start unframed");
endmodule
`default_nettype wire

/* File: tb/nand_array_model.sv */
// Array model: one page buffer, streamed on read, filled on program.
// Assumes the front end's array port on the same clk.
`timescale 1ns/1ps
`default_nettype none
module nand_array_model
    import nand_pkg::*;
(
    // Array port
    input wire logic            clk,
    input wire logic            arr_rd_start,
    input wire logic            arr_wr_start,
    output nand_pkg::byte_t     arr_rdata,
    output logic                arr_rvalid,
    input wire nand_pkg::byte_t arr_wdata,
    input wire logic            arr_wvalid,
    output logic                arr_wready
);
    byte_t pg [2176];
    int    ri = 2176;
    int    wi = 0;
    logic  tog = 1'b0;
    initial for (int i = 0; i < 2176; i++) pg[i] = 8'(i * 3);
    // Half rate, so the front end stalls on every byte
    assign arr_wready = tog;
    always @(posedge clk) begin
        tog <= !tog;
        arr_rvalid <= 1'b0;
        arr_rdata <= ~arr_rdata;
        if (arr_rd_start) ri <= 0;
        else if (tog && ri < 2176) begin
            arr_rdata <= pg[ri];
            arr_rvalid <= 1'b1;
            ri <= ri + 1;
        end
        if (arr_wvalid && arr_wready) begin
            pg[wi] <= arr_wdata;
            wi <= wi + 1;
        end
        if (arr_wr_start) wi <= 0;
    end
endmodule
`default_nettype wire

/* File: tb/test_nand_front.sv */
// Bench: mode 0 link host, x1 commands and x1/x4 replies, array model on the far port.
// Assumes design, checker and model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "nand_regs.svh"
module test_nand_front;
    import nand_pkg::*;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        link_sclk = 1'b0;
    logic        link_cs_n = 1'b1;
    logic [3:0]  dq_in = 4'h0;
    logic        prog_fail = 1'b0;
    logic [3:0]  dq_out, dq_oe;
    logic [15:0] arr_row;
    logic        arr_rd_start, arr_wr_start, arr_rvalid, arr_wvalid, arr_wready;
    byte_t       arr_rdata, arr_wdata, b;
    byte_t       rx[$];
    byte_t       fa[4] = '{`FA_LOCK, `FA_OTP, `FA_STAT, `FA_DRV};
    byte_t       rv[4] = '{8'h00, 8'h10, 8'h00, 8'h00};
    byte_t       wv[4] = '{8'hff, 8'hf0, 8'h00, 8'h60};
    byte_t       mv[5] = '{8'h0c, 8'h11, 8'h22, 8'h15, 8'h18};
    int          miscompares = 0, checked = 0, cycles = 0, nwr = 0;
    always #12.5 clk = ~clk;
    // Identifier values 3a and 6d are arbitrary
    nand_front #(.MFR_ID(8'h3a), .DEV_ID(8'h6d), .READ_CYC(40), .PROG_CYC(80)) dut (
        .clk(clk), .resetn(resetn), .link_sclk(link_sclk), .link_cs_n(link_cs_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .arr_row(arr_row),
        .arr_rd_start(arr_rd_start), .arr_wr_start(arr_wr_start), .arr_rdata(arr_rdata),
        .arr_rvalid(arr_rvalid), .arr_wdata(arr_wdata), .arr_wvalid(arr_wvalid),
        .arr_wready(arr_wready), .arr_prog_fail(prog_fail));
    nand_array_model array (.clk(clk), .arr_rd_start(arr_rd_start),
        .arr_wr_start(arr_wr_start), .arr_rdata(arr_rdata), .arr_rvalid(arr_rvalid),
        .arr_wdata(arr_wdata), .arr_wvalid(arr_wvalid), .arr_wready(arr_wready));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One frame; sampling just before the fall leaves the sync lag ample margin
    // Reply taken on 1 or 4 lanes as w says; command bytes always on one line
    task automatic xfer(input byte_t tx[$], input int n, input int w = 1);
        rx = {};
        link_cs_n = 1'b0;
        for (int i = 0; i < 8 * tx.size() + 8 * n / w; i++) begin
            dq_in[0] = (i < 8 * tx.size()) ? tx[i / 8][7 - i % 8] : 1'b0;
            tick(4);
            link_sclk = 1'b1;
            tick(4);
            b = (w == 4) ? {b[3:0], dq_out} : {b[6:0], dq_out[1]};
            link_sclk = 1'b0;
            if (i >= 8 * tx.size() && (i - 8 * tx.size()) % (8 / w) == 8 / w - 1) begin
                rx.push_back(b);
            end
        end
        link_cs_n = 1'b1;
        tick(6);
    endtask
    task automatic check(input byte_t got, input byte_t exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic getf(input byte_t a, input byte_t exp);
        xfer('{`OP_GETF, a}, 1);
        check(rx[0], exp);
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 100; i++) begin
            xfer('{`OP_GETF, `FA_STAT}, 1);
            if (rx[0][`BIT_OIP] === 1'b0) break;
        end
    endtask
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (arr_wr_start === 1'b1) nwr++;
        if (cycles == 60000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        tick(4);
        resetn = 1'b1;
        tick(4);
        foreach (fa[i]) getf(fa[i], rv[i]);
        foreach (fa[i]) xfer('{`OP_SETF, fa[i], 8'hff}, 0);
        xfer('{`OP_RESET}, 0);
        wait_ready();
        foreach (fa[i]) getf(fa[i], wv[i]);
        prog_fail = 1'b1;
        tick(1);
        prog_fail = 1'b0;
        getf(`FA_STAT, 8'h08);
        xfer('{`OP_RESET}, 0);
        getf(`FA_STAT, 8'h00);
        $display("features done");
        xfer('{`OP_WRITE_ENABLE_CMD}, 0);
        getf(`FA_STAT, 8'h02);
        xfer('{`OP_WRDI}, 0);
        getf(`FA_STAT, 8'h00);
        xfer('{`OP_PEXEC, 8'h00, 8'h00, 8'h12}, 0);
        getf(`FA_STAT, 8'h00);
        check(8'(nwr), 8'h00);
        $display("write latch done");
        xfer('{`OP_PREAD, 8'h00, 8'h00, 8'h07}, 0);
        getf(`FA_STAT, 8'h01);
        wait_ready();
        check(arr_row[7:0], 8'h07);
        xfer('{`OP_LD4, 8'h00, 8'h08, 8'hee}, 0);
        xfer('{`OP_SETF, `FA_LOCK, 8'h00}, 0);
        xfer('{`OP_LDR, 8'hf8, 8'h7f, 8'ha5, 8'h3c}, 0);
        xfer('{`OP_LD, 8'ha0, 8'h05, 8'h11, 8'h22}, 0);
        xfer('{`OP_WRITE_ENABLE_CMD}, 0);
        xfer('{`OP_PEXEC, 8'h00, 8'h01, 8'h12}, 0);
        xfer('{`OP_WRITE_ENABLE_CMD}, 0);
        getf(`FA_STAT, 8'h01);
        wait_ready();
        check(arr_row[15:8], 8'h01);
        check(8'(nwr), 8'h01);
        xfer('{`OP_PREAD, 8'h00, 8'h01, 8'h12}, 0);
        wait_ready();
        xfer('{`OP_RD1, 8'h00, 8'h04, 8'h00}, 5);
        foreach (mv[i]) check(rx[i], mv[i]);
        xfer('{`OP_RD4, 8'h00, 8'h04, 8'h00}, 2, 4);
        check(rx[0], 8'h0c);
        check(rx[1], 8'h11);
        xfer('{`OP_RDF, 8'h08, 8'h7f, 8'h00}, 2);
        check(rx[0], 8'ha5);
        check(rx[1], 8'hff);
        $display("data move done");
        xfer('{`OP_RDID, 8'h00}, 2);
        check(rx[0], 8'h3a);
        check(rx[1], 8'h6d);
        $display("identifier done");
        summarize();
    end
endmodule
bind nand_front nand_front_chk chk (.clk(clk), .resetn(resetn), .link_cs_n(link_cs_n),
    .dq_oe(dq_oe), .arr_rd_start(arr_rd_start), .arr_wr_start(arr_wr_start),
    .arr_wdata(arr_wdata), .arr_wvalid(arr_wvalid), .arr_wready(arr_wready));
`default_nettype wire
